// *** hw/xmem_decoder_pkg.sv ***
// Constants and types shared by the extended memory decoder.
package xmem_decoder_pkg;

   // Targets of a decoded request.
   typedef enum logic [2:0] {
      TGT_DRAM  = 3'b000,
      TGT_HUB   = 3'b001,
      TGT_AGP   = 3'b010,
      TGT_GFX   = 3'b011,
      TGT_ABORT = 3'b100
   } target_type;

   // Requesting interface.
   typedef enum logic [1:0] {
      SRC_CPU = 2'b00,
      SRC_HUB = 2'b01,
      SRC_AGP = 2'b10
   } source_type;

   // Register byte offsets.
   localparam logic [7:0] OFF_CTRL = 8'h00;
   localparam logic [7:0] OFF_TOM = 8'h04;
   localparam logic [7:0] OFF_WMEM_BASE = 8'h08;
   localparam logic [7:0] OFF_WMEM_LIMIT = 8'h0C;
   localparam logic [7:0] OFF_WPF_BASE = 8'h10;
   localparam logic [7:0] OFF_WPF_LIMIT = 8'h14;
   localparam logic [7:0] OFF_APER_BASE = 8'h18;
   localparam logic [7:0] OFF_APER_SIZE = 8'h1C;
   localparam logic [7:0] OFF_GLM_BASE = 8'h20;
   localparam logic [7:0] OFF_GLM_SIZE = 8'h24;
   localparam logic [7:0] OFF_GMM_BASE = 8'h28;
   localparam logic [7:0] OFF_GMM_SIZE = 8'h2C;
   localparam logic [7:0] OFF_STATUS = 8'h30;
   localparam int NUM_CFG = 12;

   // Control register field positions.
   localparam int CTRL_FIXED_HOLE_BIT = 0;
   localparam int CTRL_HIGH_PROTECTED_SEGMENT_EN_BIT = 1;
   localparam int CTRL_TOP_PROTECTED_SEGMENT_EN_BIT = 2;
   localparam int CTRL_COMPAT_EN_BIT = 3;
   localparam int CTRL_AGP_MODE_BIT = 4;
   localparam int CTRL_VGA_EN_BIT = 5;
   localparam int CTRL_MONO_BIT = 6;
   localparam int CTRL_TOP_PROTECTED_SEGMENT_SIZE_BIT = 7;
   localparam int CTRL_FB_EN_BIT = 8;
   localparam int CTRL_FB_SIZE_BIT = 9;

   // Reset values.
   localparam logic [31:0] CFG_RESET = 32'h0000_0000;
   localparam logic [31:0] STATUS_RESET = 32'h0000_0000;

   // Address map.
   localparam logic [31:0] ONE_MB = 32'h0010_0000;
   localparam logic [31:0] TOM_MAX = 32'h2000_0000;
   localparam logic [31:0] HOLE_LO = 32'h00F0_0000;
   localparam logic [31:0] HOLE_HI = 32'h00FF_FFFF;
   localparam logic [31:0] COMPAT_LO = 32'h000A_0000;
   localparam logic [31:0] COMPAT_HI = 32'h000B_FFFF;
   localparam logic [31:0] MONO_LO = 32'h000B_0000;
   localparam logic [31:0] MONO_HI = 32'h000B_7FFF;
   localparam logic [31:0] HIGH_PROTECTED_SEGMENT_LO = 32'hFEEA_0000;
   localparam logic [31:0] HIGH_PROTECTED_SEGMENT_HI = 32'hFEEB_FFFF;
   localparam logic [31:0] HIGH_PROTECTED_SEGMENT_DRAM_MASK = 32'h000F_FFFF;
   localparam logic [31:0] IOAPIC_LO = 32'hFEC0_0000;
   localparam logic [31:0] IOAPIC_HI = 32'hFECF_FFFF;
   localparam logic [31:0] HUBFIX_LO = 32'hFED0_0000;
   localparam logic [31:0] HUBFIX_HI = 32'hFFDF_FFFF;
   localparam logic [31:0] BIOS_LO = 32'hFFE0_0000;
   localparam logic [31:0] SEG_SMALL = 32'h0008_0000;
   localparam logic [31:0] SEG_LARGE = 32'h0010_0000;

endpackage

// *** hw/xmem_decoder.sv ***
// Extended memory and management RAM address decoder with APB registers.
// Notes on behaviour
// (RL1) 1 MB to capped ceiling goes to DRAM.
// (RL2) Enabled 15-16 MB hole goes to hub.
// (RL3) DRAM under the hole is not relocated.
// (RL4) Management high segment maps onto A0000h-BFFFFh.
// (RL5) Non-management high segment access is aborted.
// (RL6) Write-backs to high segment still translated.
// (RL7) Management top segment reaches DRAM untranslated.
// (RL8) Non-management top segment aborts, write-backs excepted.
// (RL9) Top segment is 512 KB or 1 MB.
// (RL10) Hub and AGP masters never reach management memory.
// (RL11) Compatible space A0000h-BFFFFh is untranslated.
// (RL12) High segment decoded at FEEA0000h-FEEBFFFFh.
// (RL13) Ceiling to 4 GB defaults to hub.
// (RL14) Graphics mode ranges go to graphics unit.
// (RL15) AGP mode windows go to AGP port.
// (RL16) AGP mode aperture goes to DRAM.
// (RL17) I/O interrupt controllers go to hub only.
// (RL18) FED00000h-FFDFFFFFh goes to hub, except the enabled high segment.
// (RL19) Top 2 MB boot firmware goes to hub.
// (RL20) Frame buffer window sits below top segment.
// (RL21) Software keeps aperture off A0000h-FFFFFh.
// (RL22) Software keeps segments clear, compatible uncached.
// (RL23) High segment disables compatible; video steering.
// (RL24) Management status taken per request sideband.
//
// The register offsets and the APB interface to the registers are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none

module xmem_decoder
   import xmem_decoder_pkg::*;
(
   input wire logic CLK,
   input wire logic RST_N,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [7:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   input wire logic REQ_VALID,
   input wire logic [31:0] REQ_ADDR,
   input wire logic [1:0] REQ_SRC,
   input wire logic REQ_SMM,
   input wire logic REQ_WRITEBACK,
   output logic RSP_VALID,
   output logic [2:0] RSP_TARGET,
   output logic [31:0] RSP_ADDR
);

   logic [31:0] cfg_reg [0:NUM_CFG-1];
   logic [31:0] status_reg;
   logic [31:0] ctrl;
   logic [31:0] tom_eff;
   logic [31:0] top_protected_segment_size;
   logic [31:0] top_protected_segment_base;
   logic [31:0] fb_size;
   logic [31:0] fb_base;
   logic hole_en, high_protected_segment_en, top_protected_segment_en, compat_en, agp_mode, vga_en, mono;
   logic fb_en, is_cpu, smm_ok, wb_ok;
   logic hit_high_protected_segment, hit_top_protected_segment, hit_compat, hit_fb;
   target_type tgt_next;
   logic [31:0] addr_next;
   logic apb_setup, apb_access, addr_mapped;
   logic [3:0] cfg_idx;

   function automatic logic in_range(input logic [31:0] a,
                                     input logic [31:0] lo,
                                     input logic [31:0] hi);
      in_range = (a >= lo) && (a <= hi);
   endfunction

   function automatic logic in_sized(input logic [31:0] a,
                                     input logic [31:0] base,
                                     input logic [31:0] size);
      in_sized = (size != 32'h0000_0000) && (a >= base) &&
                 ((a - base) < size);
   endfunction

   // Configuration fields.
   assign ctrl = cfg_reg[OFF_CTRL[5:2]];
   assign hole_en = ctrl[CTRL_FIXED_HOLE_BIT];
   assign high_protected_segment_en = ctrl[CTRL_HIGH_PROTECTED_SEGMENT_EN_BIT];
   assign top_protected_segment_en = ctrl[CTRL_TOP_PROTECTED_SEGMENT_EN_BIT];
   // The compatible space is forced off while the high segment is on.
   assign compat_en = ctrl[CTRL_COMPAT_EN_BIT] & ~high_protected_segment_en; // RL23
   assign agp_mode = ctrl[CTRL_AGP_MODE_BIT];
   assign vga_en = ctrl[CTRL_VGA_EN_BIT];
   assign mono = ctrl[CTRL_MONO_BIT];
   assign fb_en = ctrl[CTRL_FB_EN_BIT] & ~agp_mode; // RL20

   // The ceiling is capped so a bad write cannot claim PCI space.
   assign tom_eff = (cfg_reg[OFF_TOM[5:2]] > TOM_MAX) ?
                    TOM_MAX : cfg_reg[OFF_TOM[5:2]]; // RL1
   assign top_protected_segment_size = ctrl[CTRL_TOP_PROTECTED_SEGMENT_SIZE_BIT] ?
                      SEG_LARGE : SEG_SMALL; // RL9
   assign top_protected_segment_base = tom_eff - top_protected_segment_size; // RL9
   assign fb_size = ctrl[CTRL_FB_SIZE_BIT] ? SEG_LARGE : SEG_SMALL;
   assign fb_base = top_protected_segment_base - fb_size; // RL20

   // Management status and write-back flag come with each request.
   assign is_cpu = (REQ_SRC == SRC_CPU);
   assign smm_ok = is_cpu & REQ_SMM; // RL24
   assign wb_ok = is_cpu & REQ_WRITEBACK; // RL6

   assign hit_high_protected_segment = high_protected_segment_en & in_range(REQ_ADDR, HIGH_PROTECTED_SEGMENT_LO, HIGH_PROTECTED_SEGMENT_HI); // RL12
   assign hit_top_protected_segment = top_protected_segment_en &
                     in_range(REQ_ADDR, top_protected_segment_base, tom_eff - 32'h1); // RL7 RL8
   assign hit_compat = in_range(REQ_ADDR, COMPAT_LO, COMPAT_HI);
   assign hit_fb = fb_en & in_range(REQ_ADDR, fb_base, top_protected_segment_base - 32'h1);

   always_comb begin
      tgt_next = TGT_HUB; // RL13
      addr_next = REQ_ADDR;
      if (hit_high_protected_segment) begin
         // Write-backs must land so dirty lines are not lost.
         if (smm_ok || wb_ok) begin
            tgt_next = TGT_DRAM; // RL4 RL6
            addr_next = REQ_ADDR & HIGH_PROTECTED_SEGMENT_DRAM_MASK; // RL4
         end else begin
            tgt_next = TGT_ABORT; // RL5 RL10
         end
      end else if (hit_top_protected_segment) begin
         if (smm_ok || wb_ok) begin
            tgt_next = TGT_DRAM; // RL7 RL8
         end else begin
            tgt_next = TGT_ABORT; // RL8 RL10
         end
      end else if (hit_compat) begin
         if (compat_en && smm_ok) begin
            tgt_next = TGT_DRAM; // RL11
         end else if (vga_en &&
                      !(mono && in_range(REQ_ADDR, MONO_LO, MONO_HI))) begin
            tgt_next = agp_mode ? TGT_AGP : TGT_GFX; // RL23
         end else begin
            tgt_next = TGT_HUB; // RL23
         end
      end else if (REQ_ADDR < COMPAT_LO) begin
         tgt_next = TGT_DRAM;
      end else if (REQ_ADDR < ONE_MB) begin
         tgt_next = TGT_HUB;
      end else if (REQ_ADDR < tom_eff) begin
         if (hole_en && in_range(REQ_ADDR, HOLE_LO, HOLE_HI)) begin
            // Hidden DRAM stays hidden; no remap above the ceiling.
            tgt_next = TGT_HUB; // RL2 RL3
         end else if (hit_fb) begin
            tgt_next = TGT_GFX; // RL20
         end else begin
            tgt_next = TGT_DRAM; // RL1
         end
      end else if (in_range(REQ_ADDR, IOAPIC_LO, IOAPIC_HI)) begin
         tgt_next = TGT_HUB; // RL17
      end else if (in_range(REQ_ADDR, HUBFIX_LO, HUBFIX_HI)) begin
         tgt_next = TGT_HUB; // RL18
      end else if (REQ_ADDR >= BIOS_LO) begin
         tgt_next = TGT_HUB; // RL19
      end else if (!agp_mode) begin
         if (in_sized(REQ_ADDR, cfg_reg[OFF_GLM_BASE[5:2]],
                      cfg_reg[OFF_GLM_SIZE[5:2]]) ||
             in_sized(REQ_ADDR, cfg_reg[OFF_GMM_BASE[5:2]],
                      cfg_reg[OFF_GMM_SIZE[5:2]])) begin
            tgt_next = TGT_GFX; // RL14
         end
      end else begin
         if (in_sized(REQ_ADDR, cfg_reg[OFF_APER_BASE[5:2]],
                      cfg_reg[OFF_APER_SIZE[5:2]])) begin
            tgt_next = TGT_DRAM; // RL16
         end else if (in_range(REQ_ADDR, cfg_reg[OFF_WMEM_BASE[5:2]],
                               cfg_reg[OFF_WMEM_LIMIT[5:2]]) ||
                      in_range(REQ_ADDR, cfg_reg[OFF_WPF_BASE[5:2]],
                               cfg_reg[OFF_WPF_LIMIT[5:2]])) begin
            tgt_next = TGT_AGP; // RL15
         end
      end
   end

   // Decoded answer, one cycle after the request.
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         RSP_VALID <= 1'b0;
         RSP_TARGET <= TGT_HUB;
         RSP_ADDR <= 32'h0000_0000;
      end else begin
         RSP_VALID <= REQ_VALID;
         if (REQ_VALID) begin
            RSP_TARGET <= tgt_next;
            RSP_ADDR <= addr_next;
         end
      end
   end

   // Status keeps the last decode so software can see the block's state.
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         status_reg <= STATUS_RESET;
      end else if (REQ_VALID) begin
         status_reg <= {24'h00_0000, 1'b0, hit_top_protected_segment, hit_high_protected_segment,
                        (tgt_next == TGT_ABORT), 1'b0, tgt_next};
      end
   end

   // APB slave: zero wait states, error on unmapped offsets.
   assign apb_setup = PSEL & ~PENABLE;
   assign apb_access = PSEL & PENABLE;
   assign cfg_idx = PADDR[5:2];
   assign addr_mapped = (PADDR[1:0] == 2'b00) &&
                        ((PADDR <= OFF_GMM_SIZE) || (PADDR == OFF_STATUS));
   assign PREADY = 1'b1;
   assign PSLVERR = apb_access & ~addr_mapped;

   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         for (int i = 0; i < NUM_CFG; i++) begin
            cfg_reg[i] <= CFG_RESET;
         end
      end else if (apb_access && PWRITE && addr_mapped &&
                   PADDR != OFF_STATUS) begin
         cfg_reg[cfg_idx] <= PWDATA;
      end
   end

   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         PRDATA <= 32'h0000_0000;
      end else if (apb_setup && !PWRITE) begin
         if (!addr_mapped) begin
            PRDATA <= 32'h0000_0000;
         end else if (PADDR == OFF_STATUS) begin
            PRDATA <= status_reg;
         end else begin
            PRDATA <= cfg_reg[cfg_idx];
         end
      end
   end

   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RST_N);

   high_protected_segment_translate_a: assert property ( // RL4
      REQ_VALID && hit_high_protected_segment && smm_ok |=>
      RSP_TARGET == TGT_DRAM &&
      RSP_ADDR == ($past(REQ_ADDR) & HIGH_PROTECTED_SEGMENT_DRAM_MASK))
      else $error("High segment not translated.");

   high_protected_segment_abort_a: assert property ( // RL5
      REQ_VALID && hit_high_protected_segment && is_cpu && !REQ_SMM && !REQ_WRITEBACK |=>
      RSP_TARGET == TGT_ABORT)
      else $error("High segment access not aborted.");

   high_protected_segment_writeback_a: assert property ( // RL6
      REQ_VALID && hit_high_protected_segment && wb_ok |=>
      RSP_TARGET == TGT_DRAM && RSP_ADDR[31:20] == 12'h000)
      else $error("High segment write-back lost.");

   top_protected_segment_direct_a: assert property ( // RL7
      REQ_VALID && hit_top_protected_segment && smm_ok |=>
      RSP_TARGET == TGT_DRAM && RSP_ADDR == $past(REQ_ADDR))
      else $error("Top segment access translated.");

   top_protected_segment_abort_a: assert property ( // RL8
      REQ_VALID && hit_top_protected_segment && is_cpu && !REQ_SMM && !REQ_WRITEBACK |=>
      RSP_TARGET == TGT_ABORT)
      else $error("Top segment access not aborted.");

   top_protected_segment_size_a: assert property ( // RL9
      tom_eff - top_protected_segment_base == (ctrl[CTRL_TOP_PROTECTED_SEGMENT_SIZE_BIT] ?
                              SEG_LARGE : SEG_SMALL))
      else $error("Top segment size wrong.");

   master_guard_a: assert property ( // RL10
      REQ_VALID && !is_cpu && (hit_high_protected_segment || hit_top_protected_segment) |=>
      RSP_TARGET == TGT_ABORT)
      else $error("Hub or AGP master reached management memory.");

   hole_route_a: assert property ( // RL2
      REQ_VALID && hole_en && !hit_top_protected_segment && !hit_fb &&
      in_range(REQ_ADDR, HOLE_LO, HOLE_HI) |=> RSP_TARGET == TGT_HUB)
      else $error("Hole access not sent to hub.");

   ceiling_cap_a: assert property ( // RL1
      REQ_VALID && REQ_ADDR >= TOM_MAX && REQ_ADDR < HIGH_PROTECTED_SEGMENT_LO |=>
      RSP_TARGET != TGT_DRAM || $past(agp_mode))
      else $error("DRAM decoded above the ceiling.");

   fixed_hub_a: assert property ( // RL18
      REQ_VALID && !hit_high_protected_segment && in_range(REQ_ADDR, HUBFIX_LO, HUBFIX_HI)
      |=> RSP_TARGET == TGT_HUB)
      else $error("Fixed range not sent to hub.");

   answer_pulse_a: assert property (
      REQ_VALID |=> RSP_VALID ##1 (RSP_VALID == $past(REQ_VALID)))
      else $error("Answer does not follow request.");

   compat_smm_a: assert property ( // RL11
      REQ_VALID && hit_compat && !hit_high_protected_segment && !hit_top_protected_segment &&
      compat_en && smm_ok |=>
      RSP_TARGET == TGT_DRAM && RSP_ADDR == $past(REQ_ADDR))
      else $error("Compatible space not sent to DRAM.");

   compat_video_a: assert property ( // RL23
      REQ_VALID && hit_compat && !hit_high_protected_segment && !hit_top_protected_segment &&
      !(compat_en && smm_ok) && vga_en && agp_mode && !mono |=>
      RSP_TARGET == TGT_AGP)
      else $error("Video range not sent to AGP.");

   ioapic_hub_a: assert property ( // RL17
      REQ_VALID && in_range(REQ_ADDR, IOAPIC_LO, IOAPIC_HI) |=>
      RSP_TARGET == TGT_HUB)
      else $error("Interrupt controller range not sent to hub.");

   bios_hub_a: assert property ( // RL19
      REQ_VALID && REQ_ADDR >= BIOS_LO |=> RSP_TARGET == TGT_HUB)
      else $error("Boot firmware range not sent to hub.");

   aperture_dram_a: assert property ( // RL16
      REQ_VALID && agp_mode && REQ_ADDR >= tom_eff &&
      REQ_ADDR < IOAPIC_LO &&
      in_sized(REQ_ADDR, cfg_reg[OFF_APER_BASE[5:2]],
               cfg_reg[OFF_APER_SIZE[5:2]]) |=>
      RSP_TARGET == TGT_DRAM)
      else $error("Aperture not sent to DRAM.");

   window_agp_a: assert property ( // RL15
      REQ_VALID && agp_mode && REQ_ADDR >= tom_eff &&
      REQ_ADDR < IOAPIC_LO &&
      !in_sized(REQ_ADDR, cfg_reg[OFF_APER_BASE[5:2]],
                cfg_reg[OFF_APER_SIZE[5:2]]) &&
      in_range(REQ_ADDR, cfg_reg[OFF_WMEM_BASE[5:2]],
               cfg_reg[OFF_WMEM_LIMIT[5:2]]) |=>
      RSP_TARGET == TGT_AGP)
      else $error("Memory window not sent to AGP.");

   gfx_range_a: assert property ( // RL14
      REQ_VALID && !agp_mode && REQ_ADDR >= tom_eff &&
      REQ_ADDR < IOAPIC_LO &&
      in_sized(REQ_ADDR, cfg_reg[OFF_GLM_BASE[5:2]],
               cfg_reg[OFF_GLM_SIZE[5:2]]) |=>
      RSP_TARGET == TGT_GFX)
      else $error("Graphics range not sent to graphics unit.");

   pci_default_a: assert property ( // RL13
      REQ_VALID && !agp_mode && REQ_ADDR >= tom_eff &&
      REQ_ADDR < IOAPIC_LO &&
      !in_sized(REQ_ADDR, cfg_reg[OFF_GLM_BASE[5:2]],
                cfg_reg[OFF_GLM_SIZE[5:2]]) &&
      !in_sized(REQ_ADDR, cfg_reg[OFF_GMM_BASE[5:2]],
                cfg_reg[OFF_GMM_SIZE[5:2]]) |=>
      RSP_TARGET == TGT_HUB)
      else $error("Space above ceiling not sent to hub.");

   high_protected_segment_smm_c: cover property (REQ_VALID && hit_high_protected_segment && smm_ok);
   top_protected_segment_wb_c: cover property (REQ_VALID && hit_top_protected_segment && wb_ok && !REQ_SMM);
   agp_window_c: cover property (REQ_VALID ##1 RSP_TARGET == TGT_AGP);
   gfx_route_c: cover property (REQ_VALID ##1 RSP_TARGET == TGT_GFX);

endmodule

`default_nettype wire

// *** verification/xmem_requester.sv ***
// Requester model that drives the decode port on behalf of the bus masters.
`timescale 1ns/1ns
`default_nettype none

module xmem_requester
   import xmem_decoder_pkg::*;
(
   input wire logic CLK,
   output logic REQ_VALID,
   output logic [31:0] REQ_ADDR,
   output logic [1:0] REQ_SRC,
   output logic REQ_SMM,
   output logic REQ_WRITEBACK
);
   initial begin
      REQ_VALID = 1'h0;
      REQ_ADDR = 32'h0;
      REQ_SRC = SRC_CPU;
      REQ_SMM = 1'h0;
      REQ_WRITEBACK = 1'h0;
   end

   task automatic issue(input logic [31:0] a, input source_type s,
      input logic m, input logic w);
      @(posedge CLK);
      REQ_VALID <= 1'h1;
      REQ_ADDR <= a;
      REQ_SRC <= s;
      REQ_SMM <= m;
      REQ_WRITEBACK <= w;
      @(posedge CLK);
      // Address, SMM and write-back flags are inverted once the strobe drops (the source is kept), so no stale value helps.
      REQ_VALID <= 1'h0;
      REQ_ADDR <= ~a;
      REQ_SMM <= ~m;
      REQ_WRITEBACK <= ~w;
   endtask
endmodule

`default_nettype wire

// *** verification/extended_memory_smm_decoder_test.sv ***
// Self-checking bench for the extended memory decoder.
`timescale 1ns/1ns
`default_nettype none

module extended_memory_smm_decoder_test
   import xmem_decoder_pkg::*;
;
   logic clk = 1'h0;
   logic rst_n = 1'h0;
   logic psel = 1'h0;
   logic penable = 1'h0;
   logic pwrite = 1'h0;
   logic [7:0] paddr = 8'h0;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic req_valid;
   logic [31:0] req_addr;
   logic [1:0] req_src;
   logic req_smm;
   logic req_wb;
   logic rsp_valid;
   logic [2:0] rsp_target;
   logic [31:0] rsp_addr;
   logic [31:0] rd;
   logic er;
   int err_total = 0;
   int n_compared = 0;

   always #25 clk = ~clk;

   xmem_decoder i_xmem_decoder (.CLK(clk), .RST_N(rst_n), .PSEL(psel),
      .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
      .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
      .REQ_VALID(req_valid), .REQ_ADDR(req_addr), .REQ_SRC(req_src),
      .REQ_SMM(req_smm), .REQ_WRITEBACK(req_wb), .RSP_VALID(rsp_valid),
      .RSP_TARGET(rsp_target), .RSP_ADDR(rsp_addr));

   xmem_requester i_xmem_requester (.CLK(clk), .REQ_VALID(req_valid),
      .REQ_ADDR(req_addr), .REQ_SRC(req_src), .REQ_SMM(req_smm),
      .REQ_WRITEBACK(req_wb));

   task automatic chk(input string n, input logic [31:0] s,
      input logic [31:0] e);
      n_compared++;
      if (s !== e) begin
         err_total++;
         $display("unexpected %s: expected %h, seen %h", n, e, s);
      end
   endtask

   task automatic give_verdict();
      if (err_total == 0 && n_compared > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d, output logic [31:0] r, output logic e);
      int k;
      @(posedge clk);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'h1;
      for (k = 0; k < 8; k++) begin
         @(posedge clk);
         if (pready === 1'h1) break;
      end
      if (k == 8) err_total++;
      r = prdata;
      e = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'h1, a, d, rd, er);
   endtask

   task automatic rdc(input string n, input logic [7:0] a,
      input logic [31:0] e, input logic ee = 1'h0);
      apb(1'h0, a, 32'h0, rd, er);
      chk(n, rd, e);
      chk("pslverr", {31'h0, er}, {31'h0, ee});
   endtask

   function automatic logic [31:0] b(input int i);
      return 32'h1 << i;
   endfunction

   // The answer is registered, so it is judged one cycle after the strobe.
   task automatic dec(input logic [31:0] a, input target_type t,
      input source_type s = SRC_CPU, input logic m = 1'h0,
      input logic w = 1'h0, input logic [31:0] x = 32'hFFFF_FFFF);
      i_xmem_requester.issue(a, s, m, w);
      #1;
      chk("rsp_valid", {31'h0, rsp_valid}, 32'h1);
      chk("rsp_target", {29'h0, rsp_target}, {29'h0, t});
      if (t != TGT_ABORT) chk("rsp_addr", rsp_addr, (x == '1) ? a : x);
   endtask

   task automatic t_reset();
      chk("rsp_target", {29'h0, rsp_target}, {29'h0, TGT_HUB});
      rdc("ctrl", OFF_CTRL, CFG_RESET);
      rdc("status", OFF_STATUS, STATUS_RESET);
      rdc("unmapped", 8'h34, 32'h0, 1'h1);
      rdc("misaligned", 8'h01, 32'h0, 1'h1);
   endtask

   task automatic t_dram();
      wr(OFF_TOM, 32'h0400_0000);
      dec(32'h0010_0000, TGT_DRAM);
      dec(32'h00F8_0000, TGT_DRAM);
      wr(OFF_CTRL, b(CTRL_FIXED_HOLE_BIT));
      dec(32'h00F0_0000, TGT_HUB);
      dec(32'h00FF_FFFF, TGT_HUB, SRC_HUB);
      dec(32'h0100_0000, TGT_DRAM);
      wr(OFF_TOM, 32'h4000_0000);
      dec(32'h1FFF_FFFF, TGT_DRAM);
      dec(32'h2000_0000, TGT_HUB);
      wr(OFF_TOM, 32'h0400_0000);
   endtask

   task automatic t_high_protected_segment();
      wr(OFF_CTRL, b(CTRL_HIGH_PROTECTED_SEGMENT_EN_BIT));
      dec(32'hFEEA_1234, TGT_DRAM, SRC_CPU, 1'h1, 1'h0, 32'h000A_1234);
      dec(32'hFEEB_FFFF, TGT_DRAM, SRC_CPU, 1'h0, 1'h1, 32'h000B_FFFF);
      dec(32'hFEEA_0000, TGT_ABORT);
      wr(OFF_STATUS, 32'hFFFF_FFFF);
      rdc("status", OFF_STATUS, 32'h0000_0034);
      dec(32'hFEEA_0000, TGT_ABORT, SRC_HUB, 1'h1);
      dec(32'hFEE9_FFFF, TGT_HUB, SRC_CPU, 1'h1);
      dec(32'hFEEC_0000, TGT_HUB, SRC_CPU, 1'h1);
   endtask

   task automatic t_top_protected_segment();
      wr(OFF_CTRL, b(CTRL_TOP_PROTECTED_SEGMENT_EN_BIT));
      dec(32'h03F8_0000, TGT_DRAM, SRC_CPU, 1'h1);
      dec(32'h03FF_FFFF, TGT_ABORT);
      dec(32'h03FF_FFFF, TGT_DRAM, SRC_CPU, 1'h0, 1'h1);
      dec(32'h03F7_FFFF, TGT_DRAM);
      dec(32'h03F8_0000, TGT_ABORT, SRC_AGP, 1'h1, 1'h1);
      dec(32'h0400_0000, TGT_HUB, SRC_CPU, 1'h1);
      wr(OFF_CTRL, b(CTRL_TOP_PROTECTED_SEGMENT_EN_BIT) | b(CTRL_TOP_PROTECTED_SEGMENT_SIZE_BIT));
      dec(32'h03F0_0000, TGT_ABORT);
      dec(32'h03EF_FFFF, TGT_DRAM);
   endtask

   task automatic t_compat();
      wr(OFF_CTRL, b(CTRL_COMPAT_EN_BIT));
      dec(32'h000A_0000, TGT_DRAM, SRC_CPU, 1'h1);
      dec(32'h000B_FFFF, TGT_HUB);
      dec(32'h000A_0000, TGT_HUB, SRC_HUB, 1'h1);
      wr(OFF_CTRL, b(CTRL_COMPAT_EN_BIT) | b(CTRL_AGP_MODE_BIT)
         | b(CTRL_VGA_EN_BIT));
      dec(32'h000A_0000, TGT_AGP);
      wr(OFF_CTRL, b(CTRL_AGP_MODE_BIT) | b(CTRL_VGA_EN_BIT)
         | b(CTRL_MONO_BIT));
      dec(32'h000B_0000, TGT_HUB);
      dec(32'h000B_7FFF, TGT_HUB);
      dec(32'h000B_8000, TGT_AGP);
   endtask

   task automatic t_agp();
      wr(OFF_CTRL, b(CTRL_AGP_MODE_BIT));
      wr(OFF_WMEM_BASE, 32'hA000_0000);
      wr(OFF_WMEM_LIMIT, 32'hA0FF_FFFF);
      wr(OFF_WPF_BASE, 32'hB000_0000);
      wr(OFF_WPF_LIMIT, 32'hB00F_FFFF);
      wr(OFF_APER_BASE, 32'hC000_0000);
      wr(OFF_APER_SIZE, 32'h1000_0000);
      dec(32'hA0FF_FFFF, TGT_AGP);
      dec(32'hA100_0000, TGT_HUB);
      dec(32'hB000_0000, TGT_AGP, SRC_HUB);
      dec(32'hCFFF_FFFC, TGT_DRAM);
      dec(32'hFEC0_F000, TGT_HUB);
      dec(32'hFED0_0000, TGT_HUB);
      dec(32'hFFDF_FFFF, TGT_HUB);
      dec(32'hFFE0_0000, TGT_HUB);
      dec(32'hFFFF_FFFF, TGT_HUB);
   endtask

   task automatic t_gfx();
      wr(OFF_CTRL, b(CTRL_TOP_PROTECTED_SEGMENT_EN_BIT) | b(CTRL_FB_EN_BIT)
         | b(CTRL_FB_SIZE_BIT));
      wr(OFF_GLM_BASE, 32'h8000_0000);
      wr(OFF_GLM_SIZE, 32'h0100_0000);
      wr(OFF_GMM_BASE, 32'h9000_0000);
      wr(OFF_GMM_SIZE, 32'h0008_0000);
      dec(32'h80FF_FFFF, TGT_GFX);
      dec(32'h9007_FFFF, TGT_GFX);
      dec(32'h9008_0000, TGT_HUB);
      dec(32'h03E8_0000, TGT_GFX);
      dec(32'h03F7_FFFF, TGT_GFX);
      dec(32'h03E7_FFFF, TGT_DRAM);
      dec(32'hA000_0000, TGT_HUB);
      dec(32'hC000_0000, TGT_HUB);
   endtask

   initial begin
      repeat (20) @(posedge clk);
      rst_n <= 1'h1;
      @(posedge clk);
      t_reset();
      t_dram();
      t_high_protected_segment();
      t_top_protected_segment();
      t_compat();
      t_agp();
      t_gfx();
      give_verdict();
   end

   // The whole sequence needs well under a thousand cycles.
   initial begin
      #250000;
      err_total++;
      give_verdict();
   end
endmodule

`default_nettype wire
